// ---- hw/gee_pkg.sv ----
// Purpose: Shared constants and types of the guest event exit control block.
// Assumes: 32-bit classic Wishbone register access on byte addresses.
// Notes:   All control state resets to zero, which leaves the core in root operation.
package gee_pkg;
  localparam logic [7:0] OFS_BITMAP   = 8'h00;
  localparam logic [7:0] OFS_PF_MASK  = 8'h04;
  localparam logic [7:0] OFS_PF_MATCH = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0C;
  localparam logic [7:0] OFS_GSTATE   = 8'h10;
  localparam logic [7:0] OFS_REASON   = 8'h14;
  localparam logic [7:0] OFS_INFO     = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1C;

  localparam int CB_EXT  = 0;
  localparam int CB_NMI  = 1;
  localparam int CB_VNMI = 2;
  localparam int CB_WIN  = 3;
  localparam int CB_ACK  = 4;
  localparam int CB_HIF  = 5;
  localparam int CTRL_W  = 6;

  localparam int GS_STI = 0;
  localparam int GS_SS  = 1;
  localparam int GS_SMI = 2;
  localparam int GS_NMI = 3;

  localparam logic [15:0] RSN_EXC_NMI = 16'h0000;
  localparam logic [15:0] RSN_EXT     = 16'h0001;
  localparam logic [15:0] RSN_TRIPLE  = 16'h0002;
  localparam logic [15:0] RSN_INIT    = 16'h0003;
  localparam logic [15:0] RSN_STARTUP_PROCESSOR_REQUEST    = 16'h0004;
  localparam logic [15:0] RSN_NMI_WIN = 16'h0008;

  localparam logic [4:0] VEC_PF    = 5'h0E;
  localparam logic [7:0] VEC_NMI   = 8'h02;
  localparam logic [2:0] ITYPE_EXT = 3'h0;
  localparam logic [2:0] ITYPE_NMI = 3'h2;
  localparam logic [2:0] ITYPE_HW  = 3'h3;

  typedef enum logic [2:0] {
    ST_ROOT      = 3'b000,
    ST_GUEST     = 3'b001,
    ST_ACK_EXIT  = 3'b010,
    ST_ACK_GUEST = 3'b011,
    ST_ACK_ROOT  = 3'b100
  } phase_t;
endpackage

// ---- hw/exit_cause_if.sv ----
// Purpose: Carries guest events and settings to the exit judge and its verdict back.
// Assumes: All signals belong to ref_clk.
// Notes:   The verdict is combinational.
interface exit_cause_if;
  logic        in_guest;
  logic        management_mode;
  logic [31:0] bitmap;
  logic [31:0] pf_mask;
  logic [31:0] pf_match;
  logic [5:0]  ctrl;
  logic [3:0]  blk;
  logic        guest_if;
  logic        exc_valid;
  logic [4:0]  exc_vec;
  logic [31:0] pf_ec;
  logic        dbl_nested;
  logic        ext_req;
  logic        nmi_req;
  logic        init_req;
  logic        startup_processor_request_req;
  logic        hit;
  logic [15:0] reason;
  logic        dlv_exc;
  logic        dlv_nmi;
  logic        dlv_ext;
  modport core (output in_guest, management_mode, bitmap, pf_mask, pf_match, ctrl, blk, guest_if, exc_valid,
                output exc_vec, pf_ec, dbl_nested, ext_req, nmi_req, init_req, startup_processor_request_req,
                input hit, reason, dlv_exc, dlv_nmi, dlv_ext);
  modport judge (input in_guest, management_mode, bitmap, pf_mask, pf_match, ctrl, blk, guest_if, exc_valid,
                 input exc_vec, pf_ec, dbl_nested, ext_req, nmi_req, init_req, startup_processor_request_req,
                 output hit, reason, dlv_exc, dlv_nmi, dlv_ext);
endinterface

// ---- hw/exit_decide.sv ----
// Purpose: Picks, for one guest cycle, the single exit or delivery that wins.
// Assumes: Inputs are stable within the cycle.
// Notes:   Priority is restart, startup, triple fault, exception, NMI, external, NMI window.
module exit_decide (
  exit_cause_if.judge cif
);
  logic bit_sel;
  logic pf_qual;
  logic exc_exit;
  logic ext_ok;
  logic nmi_free;

  always_comb begin
    bit_sel  = cif.bitmap[cif.exc_vec];
    pf_qual  = (cif.pf_ec & cif.pf_mask) == cif.pf_match;
    // A page fault exits on a set bit when the code matches and on a clear bit otherwise.
    exc_exit = (cif.exc_vec == gee_pkg::VEC_PF) ? (bit_sel == pf_qual) : bit_sel;
    ext_ok   = cif.guest_if && !cif.blk[gee_pkg::GS_STI] && !cif.blk[gee_pkg::GS_SS];
    nmi_free = !cif.blk[gee_pkg::GS_NMI];
    cif.hit     = 1'b0;
    cif.reason  = gee_pkg::RSN_EXC_NMI;
    cif.dlv_exc = 1'b0;
    cif.dlv_nmi = 1'b0;
    cif.dlv_ext = 1'b0;
    if (!cif.in_guest) begin
      cif.hit = 1'b0;
    end else if (cif.init_req && !cif.management_mode) begin
      cif.hit    = 1'b1;
      cif.reason = gee_pkg::RSN_INIT;
    end else if (cif.startup_processor_request_req) begin
      cif.hit    = 1'b1;
      cif.reason = gee_pkg::RSN_STARTUP_PROCESSOR_REQUEST;
    end else if (cif.exc_valid && cif.dbl_nested && !exc_exit) begin
      cif.hit    = 1'b1;
      cif.reason = gee_pkg::RSN_TRIPLE;
    end else if (cif.exc_valid && exc_exit) begin
      cif.hit = 1'b1;
    end else if (cif.exc_valid) begin
      cif.dlv_exc = 1'b1;
    end else if (cif.nmi_req && nmi_free) begin
      cif.hit     = cif.ctrl[gee_pkg::CB_NMI] || cif.ctrl[gee_pkg::CB_VNMI];
      cif.dlv_nmi = !cif.hit;
    end else if (cif.ext_req && cif.ctrl[gee_pkg::CB_EXT]) begin
      cif.hit    = 1'b1;
      cif.reason = gee_pkg::RSN_EXT;
    end else if (cif.ext_req && ext_ok) begin
      cif.dlv_ext = 1'b1;
    end else if (cif.ctrl[gee_pkg::CB_VNMI] && cif.ctrl[gee_pkg::CB_WIN] && nmi_free) begin
      cif.hit    = 1'b1;
      cif.reason = gee_pkg::RSN_NMI_WIN;
    end
  end
endmodule

// ---- hw/guest_event_exit_control.sv ----
// Purpose: Decides exit or guest delivery for guest events and tracks interruptibility.
// Assumes: Core event inputs and the interrupt controller run on ref_clk; no synchronisers.
// Notes:   Event inputs are one-cycle pulses except ext_intr_req, which is a level.
// What this block does
// - A set exception bitmap bit makes that guest exception exit to the monitor.
// - A clear bitmap bit delivers the exception through the guest vector table.
// - Range-check, overflow-trap and breakpoint exceptions follow the same bitmap.
// - Page fault exits are qualified by error code mask and match fields.
// - A fault while calling the double-fault handler, not selected, exits as triple fault.
// - External exit control clear: no exit, delivery gated by guest interrupt flag.
// - External exit control set: every external interrupt exits, flag ignored.
// - External interrupt exits report basic reason code 1.
// - A control selects exit or no exit for non-maskable interrupts.
// - Virtual NMI control makes NMIs exit and tracks guest NMI readiness.
// - Startup requests always exit from the guest; soft restart exits only outside management mode.
// - Acknowledge-on-exit fetches the vector and stores it in the exit information.
// - Without acknowledge-on-exit the interrupt stays pending at the controller.
// - External exits clear the interrupt flag; setting it later acknowledges and vectors.
// - Blocking state covers flag-set, stack load, management and NMI blocking.
// - Soft restart is blocked in root operation and in management mode.
// - Startup requests are blocked throughout root operation.
// - Entry loads interruptibility state from the guest area; exit saves it back.
// - Virtual NMI plus window control exits once NMI blocking ends, reason 8.
module guest_event_exit_control (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  input  wire logic        vm_entry,
  input  wire logic        insn_retire,
  input  wire logic        sti_exec,
  input  wire logic        ss_load,
  input  wire logic        interrupt_return_op_exec,
  input  wire logic        rsm_exec,
  input  wire logic        smi_taken,
  input  wire logic        smm_active,
  input  wire logic        guest_if_flag,
  input  wire logic        exc_valid,
  input  wire logic [4:0]  exc_vector,
  input  wire logic [31:0] pf_error_code,
  input  wire logic        dbl_fault_nested,
  input  wire logic        ext_intr_req,
  input  wire logic        nmi_req,
  input  wire logic        init_req,
  input  wire logic        startup_processor_request_req,
  output      logic        intack_req,
  input  wire logic        intack_done,
  input  wire logic [7:0]  intack_vector,
  output      logic        exit_pulse,
  output      logic [15:0] exit_reason,
  output      logic [31:0] exit_info,
  output      logic        deliver_pulse,
  output      logic [7:0]  deliver_vector,
  output      logic        host_deliver,
  output      logic [7:0]  host_vector,
  output      logic        in_guest,
  output      logic        init_blocked,
  output      logic        startup_processor_request_blocked,
  output      logic        vnmi_ready
);
  typedef struct packed {
    gee_pkg::phase_t ph;
    logic            ack;
    logic [31:0]     rdat;
    logic [31:0]     bitmap;
    logic [31:0]     pf_mask;
    logic [31:0]     pf_match;
    logic [5:0]      ctrl;
    logic [3:0]      saved;
    logic [3:0]      live;
    logic [15:0]     reason;
    logic [31:0]     info;
    logic            exit_p;
    logic            dlv_p;
    logic            host_p;
    logic [7:0]      dvec;
    logic [7:0]      hvec;
  } state_t;

  state_t      c;
  state_t      n;
  logic        req;
  logic [7:0]  adr;
  logic [31:0] status;
  logic        go_exit;
  logic [15:0] ex_rsn;
  logic [31:0] ex_info;

  exit_cause_if cif ();

  exit_decide u_decide (
    .cif (cif)
  );

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] info_word(input logic [2:0] kind, input logic [7:0] vec);
    return {1'b1, 20'h0_0000, kind, vec};
  endfunction

  assign req = wb_cyc_i && wb_stb_i;
  assign adr = {wb_adr_i[7:2], 2'b00};

  assign cif.in_guest   = c.ph == gee_pkg::ST_GUEST;
  assign cif.management_mode        = smm_active;
  assign cif.bitmap     = c.bitmap;
  assign cif.pf_mask    = c.pf_mask;
  assign cif.pf_match   = c.pf_match;
  assign cif.ctrl       = c.ctrl;
  assign cif.blk        = c.live;
  assign cif.guest_if   = guest_if_flag;
  assign cif.exc_valid  = exc_valid;
  assign cif.exc_vec    = exc_vector;
  assign cif.pf_ec      = pf_error_code;
  assign cif.dbl_nested = dbl_fault_nested;
  assign cif.ext_req    = ext_intr_req;
  assign cif.nmi_req    = nmi_req;
  assign cif.init_req   = init_req;
  assign cif.startup_processor_request_req   = startup_processor_request_req;

  assign in_guest     = c.ph == gee_pkg::ST_GUEST;
  assign init_blocked = (c.ph != gee_pkg::ST_GUEST) || smm_active;
  assign startup_processor_request_blocked = c.ph != gee_pkg::ST_GUEST;
  assign vnmi_ready   = c.ctrl[gee_pkg::CB_VNMI] && !c.live[gee_pkg::GS_NMI];
  // The controller sees a request only in the acknowledge phases, never on a plain exit.
  assign intack_req   = (c.ph == gee_pkg::ST_ACK_EXIT) || (c.ph == gee_pkg::ST_ACK_GUEST)
                        || (c.ph == gee_pkg::ST_ACK_ROOT);
  assign status       = {26'h000_0000, intack_req, ext_intr_req, vnmi_ready, startup_processor_request_blocked,
                         init_blocked, in_guest};

  assign wb_ack_o       = c.ack;
  assign wb_dat_o       = c.rdat;
  assign exit_pulse     = c.exit_p;
  assign exit_reason    = c.reason;
  assign exit_info      = c.info;
  assign deliver_pulse  = c.dlv_p;
  assign deliver_vector = c.dvec;
  assign host_deliver   = c.host_p;
  assign host_vector    = c.hvec;

  always_comb begin
    n        = c;
    go_exit  = 1'b0;
    ex_rsn   = gee_pkg::RSN_EXC_NMI;
    ex_info  = 32'h0000_0000;
    n.exit_p = 1'b0;
    n.dlv_p  = 1'b0;
    n.host_p = 1'b0;
    n.ack    = req && !c.ack;
    // Read data is fetched one cycle early so that it stands together with ack.
    if (req && !c.ack) begin
      case (adr)
        gee_pkg::OFS_BITMAP:   n.rdat = c.bitmap;
        gee_pkg::OFS_PF_MASK:  n.rdat = c.pf_mask;
        gee_pkg::OFS_PF_MATCH: n.rdat = c.pf_match;
        gee_pkg::OFS_CTRL:     n.rdat = {26'h000_0000, c.ctrl};
        gee_pkg::OFS_GSTATE:   n.rdat = {28'h000_0000, c.saved};
        gee_pkg::OFS_REASON:   n.rdat = {16'h0000, c.reason};
        gee_pkg::OFS_INFO:     n.rdat = c.info;
        gee_pkg::OFS_STATUS:   n.rdat = status;
        default:               n.rdat = 32'h0000_0000;
      endcase
    end
    // Writes land on the edge at which the master samples ack.
    if (req && c.ack && wb_we_i) begin
      case (adr)
        gee_pkg::OFS_BITMAP:   n.bitmap = wmerge(c.bitmap, wb_dat_i, wb_sel_i);
        gee_pkg::OFS_PF_MASK:  n.pf_mask = wmerge(c.pf_mask, wb_dat_i, wb_sel_i);
        gee_pkg::OFS_PF_MATCH: n.pf_match = wmerge(c.pf_match, wb_dat_i, wb_sel_i);
        gee_pkg::OFS_CTRL:     n.ctrl = 6'(wmerge({26'h000_0000, c.ctrl}, wb_dat_i, wb_sel_i));
        gee_pkg::OFS_GSTATE:   n.saved = 4'(wmerge({28'h000_0000, c.saved}, wb_dat_i, wb_sel_i));
        default:               n.rdat = n.rdat;
      endcase
    end
    // Blocking state: clears first, so a new block in the same cycle wins.
    if (insn_retire) begin
      n.live[gee_pkg::GS_STI] = 1'b0;
      n.live[gee_pkg::GS_SS]  = 1'b0;
    end
    if (interrupt_return_op_exec || rsm_exec) begin
      n.live[gee_pkg::GS_NMI] = 1'b0;
    end
    if (rsm_exec) begin
      n.live[gee_pkg::GS_SMI] = 1'b0;
    end
    if (sti_exec) begin
      n.live[gee_pkg::GS_STI] = 1'b1;
    end
    if (ss_load) begin
      n.live[gee_pkg::GS_SS] = 1'b1;
    end
    if (smi_taken) begin
      n.live[gee_pkg::GS_SMI] = 1'b1;
      n.live[gee_pkg::GS_NMI] = 1'b1;
    end
    unique case (c.ph)
      gee_pkg::ST_ROOT: begin
        if (vm_entry) begin
          n.ph   = gee_pkg::ST_GUEST;
          n.live = c.saved;
        end else if (ext_intr_req && c.ctrl[gee_pkg::CB_HIF]) begin
          n.ph = gee_pkg::ST_ACK_ROOT;
        end
      end
      gee_pkg::ST_GUEST: begin
        if (cif.hit && cif.reason == gee_pkg::RSN_EXT && c.ctrl[gee_pkg::CB_ACK]) begin
          n.ph = gee_pkg::ST_ACK_EXIT;
        end else if (cif.hit) begin
          go_exit = 1'b1;
          ex_rsn  = cif.reason;
          if (cif.reason == gee_pkg::RSN_EXC_NMI) begin
            ex_info = exc_valid ? info_word(gee_pkg::ITYPE_HW, {3'h0, exc_vector})
                                : info_word(gee_pkg::ITYPE_NMI, gee_pkg::VEC_NMI);
          end
        end else if (cif.dlv_exc) begin
          n.dlv_p = 1'b1;
          n.dvec  = {3'h0, exc_vector};
        end else if (cif.dlv_nmi) begin
          n.dlv_p = 1'b1;
          n.dvec  = gee_pkg::VEC_NMI;
          n.live[gee_pkg::GS_NMI] = 1'b1;
        end else if (cif.dlv_ext) begin
          n.ph = gee_pkg::ST_ACK_GUEST;
        end
      end
      gee_pkg::ST_ACK_EXIT: begin
        if (intack_done) begin
          go_exit = 1'b1;
          ex_rsn  = gee_pkg::RSN_EXT;
          ex_info = info_word(gee_pkg::ITYPE_EXT, intack_vector);
        end
      end
      gee_pkg::ST_ACK_GUEST: begin
        if (intack_done) begin
          n.ph    = gee_pkg::ST_GUEST;
          n.dlv_p = 1'b1;
          n.dvec  = intack_vector;
        end
      end
      gee_pkg::ST_ACK_ROOT: begin
        if (intack_done) begin
          n.ph     = gee_pkg::ST_ROOT;
          n.host_p = 1'b1;
          n.hvec   = intack_vector;
        end
      end
      default: begin
        n.ph = gee_pkg::ST_ROOT;
      end
    endcase
    if (go_exit) begin
      n.ph     = gee_pkg::ST_ROOT;
      n.exit_p = 1'b1;
      n.reason = ex_rsn;
      n.info   = ex_info;
      n.saved  = n.live;
      if (ex_rsn == gee_pkg::RSN_EXT) begin
        n.ctrl[gee_pkg::CB_HIF] = 1'b0;
      end
    end
  end

  // Everything, including the phase, resets to zero, which is root operation.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      c <= '0;
    end else begin
      c <= n;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  logic quiet;
  assign quiet = !exc_valid && !nmi_req && !init_req && !startup_processor_request_req;

  a_bitmap_exc_exit: assert property (
    c.ph == gee_pkg::ST_GUEST && exc_valid && c.bitmap[exc_vector] && exc_vector != gee_pkg::VEC_PF
    && !init_req && !startup_processor_request_req |=> exit_pulse && exit_reason == 16'h0000 && exit_info[4:0] == $past(exc_vector))
    else $error("Selected exception did not exit.");

  a_clear_bit_dlv: assert property (
    c.ph == gee_pkg::ST_GUEST && exc_valid && !c.bitmap[exc_vector] && exc_vector != gee_pkg::VEC_PF
    && !dbl_fault_nested && !init_req && !startup_processor_request_req
    |=> deliver_pulse && !exit_pulse && deliver_vector == {3'h0, $past(exc_vector)})
    else $error("Unselected exception was not delivered to the guest.");

  a_ext_exit_reason: assert property (
    c.ph == gee_pkg::ST_GUEST && quiet && ext_intr_req && c.ctrl[0] && !c.ctrl[4]
    |=> exit_pulse && exit_reason == 16'h0001 && !c.ctrl[5])
    else $error("External interrupt did not exit with reason 1.");

  a_ack_vector_kept: assert property (
    c.ph == gee_pkg::ST_ACK_EXIT && intack_done
    |=> exit_pulse && exit_info[7:0] == $past(intack_vector) && exit_info[31])
    else $error("Acknowledged vector not stored on exit.");

  a_no_ack_pending: assert property (
    exit_pulse && exit_reason == 16'h0001 && !c.ctrl[4] |-> !$past(intack_req))
    else $error("Interrupt acknowledged although acknowledge-on-exit is clear.");

  a_restart_exits: assert property (
    c.ph == gee_pkg::ST_GUEST && init_req && !smm_active |=> exit_pulse && exit_reason == 16'h0003)
    else $error("Soft restart in the guest did not exit.");

  a_root_blocks: assert property (
    c.ph != gee_pkg::ST_GUEST |-> init_blocked && startup_processor_request_blocked)
    else $error("Restart or startup not blocked in root operation.");

  a_entry_loads: assert property (
    c.ph == gee_pkg::ST_ROOT && vm_entry && !insn_retire && !sti_exec && !ss_load && !interrupt_return_op_exec
    && !rsm_exec && !smi_taken |=> in_guest && c.live == $past(c.saved))
    else $error("Entry did not load the blocking state.");

  a_sti_one_insn: assert property (
    c.live[0] && insn_retire && !sti_exec |=> !c.live[0] ##1 (!c.live[0] || $past(sti_exec)))
    else $error("Flag-set blocking outlived one instruction.");

  a_nmi_window: assert property (
    c.ph == gee_pkg::ST_GUEST && quiet && !ext_intr_req && c.ctrl[2] && c.ctrl[3] && !c.live[3]
    |=> exit_pulse && exit_reason == 16'h0008)
    else $error("NMI window exit missing.");

  c_ack_exit: cover property (c.ph == gee_pkg::ST_ACK_EXIT ##1 exit_pulse);
  c_host_vector: cover property (exit_pulse && exit_reason == 16'h0001 ##[1:50] host_deliver);
  c_entry_exit: cover property (vm_entry ##[1:20] exit_pulse);
endmodule

// ---- tb/intc_model.sv ----
// Purpose: Behavioural platform interrupt controller that answers acknowledge cycles.
// Assumes: Same clock as the block; one interrupt pending at a time.
// Notes:   The vector lines toggle outside the answer, so a stale vector is never mistaken for a fresh one.
module intc_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       raise,
  input  wire logic [7:0] vec,
  input  wire logic [3:0] gap,
  input  wire logic       intack_req,
  output      logic       intack_done,
  output      logic [7:0] intack_vector,
  output      logic       ext_intr_req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_ff;
  always_ff @(posedge ref_clk) begin
    intack_done <= 1'b0;
    intack_vector <= ~intack_vector;
    if (!rst_n) begin
      ext_intr_req <= 1'b0;
      intack_vector <= 8'h00;
      wait_ff <= 4'h0;
    end else if (raise) begin
      ext_intr_req <= 1'b1;
    end else if (intack_req && ext_intr_req) begin
      if (wait_ff == gap) begin
        intack_done <= 1'b1;
        intack_vector <= vec;
        ext_intr_req <= 1'b0;
        wait_ff <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule

// ---- tb/guest_event_exit_control_bench.sv ----
// Purpose: Self-checking bench for the guest event exit control block.
// Assumes: One 40 MHz clock; inputs change by non-blocking assignment at rising edges.
// Notes:   Interrupt vectors are arbitrary; the controller answers both promptly and slowly.
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module guest_event_exit_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, smm_active, guest_if_flag;
  logic        dbl_fault_nested, ext_intr_req, intack_req, intack_done, exit_pulse, deliver_pulse;
  logic        host_deliver, in_guest, init_blocked, startup_processor_request_blocked, vnmi_ready;
  logic [3:0]  wb_sel_i, gap;
  logic [4:0]  exc_vector;
  logic [7:0]  wb_adr_i, intack_vector, deliver_vector, host_vector, vec;
  logic [11:0] evs;
  logic [15:0] exit_reason;
  logic [31:0] wb_dat_i, wb_dat_o, pf_error_code, exit_info, rd;
  logic [4:0]  vl [4] = '{5'h03, 5'h04, 5'h05, 5'h0D};
  int          bad_count, comparisons;

  guest_event_exit_control i_guest_event_exit_control (
    .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .vm_entry(evs[0]), .insn_retire(evs[1]), .sti_exec(evs[2]), .ss_load(evs[3]), .interrupt_return_op_exec(evs[4]),
    .rsm_exec(evs[5]), .smi_taken(evs[6]), .smm_active, .guest_if_flag, .exc_valid(evs[7]), .exc_vector,
    .pf_error_code, .dbl_fault_nested, .ext_intr_req, .nmi_req(evs[8]), .init_req(evs[9]), .startup_processor_request_req(evs[10]),
    .intack_req, .intack_done, .intack_vector, .exit_pulse, .exit_reason, .exit_info, .deliver_pulse,
    .deliver_vector, .host_deliver, .host_vector, .in_guest, .init_blocked, .startup_processor_request_blocked, .vnmi_ready
  );
  intc_model i_intc_model (
    .ref_clk, .rst_n, .raise(evs[11]), .vec, .gap, .intack_req, .intack_done, .intack_vector, .ext_intr_req
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("Counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The request is held until ack is sampled high; read data is taken at that edge only.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1) `CHK(wb_ack_o, 1'b1)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic pulse(input logic [11:0] m);
    @(posedge ref_clk);
    evs <= m;
    @(posedge ref_clk);
    evs <= 12'h000;
  endtask

  task automatic exc(input logic [4:0] v, input logic [31:0] c, input logic d);
    @(posedge ref_clk);
    {exc_vector, pf_error_code, dbl_fault_nested} <= {v, c, d};
    pulse(12'h080);
  endtask

  task automatic irq(input logic [7:0] v, input logic [3:0] g);
    @(posedge ref_clk);
    {vec, gap} <= {v, g};
    pulse(12'h800);
  endtask

  // Entry is skipped while still in the guest, since the block ignores it there.
  task automatic enter();
    if (in_guest !== 1'b1) pulse(12'h001);
    @(negedge ref_clk);
  endtask

  // Kind: 1 exit, 2 guest delivery, 4 host delivery, 0 nothing within the wait.
  task automatic outcome(input logic [2:0] k, input logic [15:0] r, input logic [31:0] f);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ({host_deliver, deliver_pulse, exit_pulse} === 3'h0 && n < 40);
    `CHK({host_deliver, deliver_pulse, exit_pulse}, k)
    if (k == 3'h1) begin
      `CHK(exit_reason, r)
      `CHK(exit_info, f)
    end
    if (k == 3'h2) `CHK(deliver_vector, f[7:0])
    if (k == 3'h4) `CHK(host_vector, f[7:0])
  endtask

  initial begin
    {ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, smm_active, guest_if_flag, dbl_fault_nested} = '0;
    {wb_adr_i, wb_dat_i, exc_vector, pf_error_code, vec, gap, evs} = '0;
    {bad_count, comparisons} = '0;
    wb_sel_i = 4'hF;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk(gee_pkg::OFS_STATUS, 32'h0000_0006);
    rchk(8'h40, 32'h0000_0000);
    wb(1'b1, gee_pkg::OFS_BITMAP, 32'h0000_6010);
    wb(1'b1, gee_pkg::OFS_PF_MASK, 32'h0000_000F);
    wb(1'b1, gee_pkg::OFS_PF_MATCH, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      enter();
      exc(vl[i], 32'h0000_0000, 1'b0);
      if (vl[i] inside {5'h04, 5'h0D}) outcome(3'h1, 16'h0000, 32'h8000_0300 | vl[i]);
      else outcome(3'h2, 16'h0000, {27'h0, vl[i]});
    end
    enter();
    exc(gee_pkg::VEC_PF, 32'h0000_0012, 1'b0);
    outcome(3'h1, gee_pkg::RSN_EXC_NMI, 32'h8000_030E);
    enter();
    exc(gee_pkg::VEC_PF, 32'h0000_0013, 1'b0);
    outcome(3'h2, 16'h0000, 32'h0000_000E);
    exc(5'h0B, 32'h0000_0000, 1'b1);
    outcome(3'h1, gee_pkg::RSN_TRIPLE, 32'h0000_0000);
    enter();
    irq(8'h41, 4'h0);
    outcome(3'h0, 16'h0000, 32'h0000_0000);
    @(posedge ref_clk) guest_if_flag <= 1'b1;
    outcome(3'h2, 16'h0000, 32'h0000_0041);
    @(posedge ref_clk) guest_if_flag <= 1'b0;
    pulse(12'h200);
    outcome(3'h1, gee_pkg::RSN_INIT, 32'h0000_0000);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_0031);
    enter();
    irq(8'h52, 4'hF);
    rchk(gee_pkg::OFS_STATUS, 32'h0000_0036);
    outcome(3'h1, gee_pkg::RSN_EXT, 32'h8000_0052);
    rchk(gee_pkg::OFS_CTRL, 32'h0000_0011);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_0001);
    enter();
    irq(8'h63, 4'h1);
    outcome(3'h1, gee_pkg::RSN_EXT, 32'h0000_0000);
    rchk(gee_pkg::OFS_STATUS, 32'h0000_0016);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_0021);
    outcome(3'h4, 16'h0000, 32'h0000_0063);
    wb(1'b1, gee_pkg::OFS_GSTATE, 32'h0000_0000);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_0002);
    enter();
    pulse(12'h100);
    outcome(3'h1, gee_pkg::RSN_EXC_NMI, 32'h8000_0202);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_0000);
    enter();
    pulse(12'h100);
    outcome(3'h2, 16'h0000, 32'h0000_0002);
    pulse(12'h100);
    outcome(3'h0, 16'h0000, 32'h0000_0000);
    pulse(12'h400);
    outcome(3'h1, gee_pkg::RSN_STARTUP_PROCESSOR_REQUEST, 32'h0000_0000);
    rchk(gee_pkg::OFS_GSTATE, 32'h0000_0008);
    wb(1'b1, gee_pkg::OFS_GSTATE, 32'h0000_0000);
    enter();
    rchk(gee_pkg::OFS_STATUS, 32'h0000_0001);
    @(posedge ref_clk) smm_active <= 1'b1;
    rchk(gee_pkg::OFS_STATUS, 32'h0000_0003);
    @(posedge ref_clk) smm_active <= 1'b0;
    pulse(12'h04C);
    pulse(12'h200);
    outcome(3'h1, gee_pkg::RSN_INIT, 32'h0000_0000);
    rchk(gee_pkg::OFS_GSTATE, 32'h0000_000F);
    enter();
    pulse(12'h032);
    pulse(12'h200);
    outcome(3'h1, gee_pkg::RSN_INIT, 32'h0000_0000);
    rchk(gee_pkg::OFS_GSTATE, 32'h0000_0000);
    wb(1'b1, gee_pkg::OFS_GSTATE, 32'h0000_0008);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_000C);
    enter();
    `CHK(vnmi_ready, 1'b0)
    pulse(12'h010);
    outcome(3'h1, gee_pkg::RSN_NMI_WIN, 32'h0000_0000);
    wb(1'b1, gee_pkg::OFS_GSTATE, 32'h0000_0000);
    wb(1'b1, gee_pkg::OFS_CTRL, 32'h0000_0004);
    enter();
    `CHK(vnmi_ready, 1'b1)
    pulse(12'h100);
    outcome(3'h1, gee_pkg::RSN_EXC_NMI, 32'h8000_0202);
    complete_run();
  end

  // About 300 cycles of tests; the limit leaves wide margin.
  initial begin
    #150000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
